/* common/dac_regs_pkg.sv */
// Purpose: shared constants of the analog output board register bank
// Assumes: 100 MHz mclk, 32-bit word registers at byte offsets
// Notes:   times are kept in ms, cycle counts derive from the clock rate
package dac_regs_pkg;
    localparam int          CLK_KHZ         = 100000;
    localparam int          BUS_CFG_TIME_MS = 3;
    localparam int          LOGIC_CFG_MS    = 300;
    localparam int          INIT_TIME_MS    = 3;

    // ms counts convert exactly to cycles, never below one cycle
    function automatic int ms_to_cycles(input int ms);
        int c;
        c = ms * CLK_KHZ;
        return (c < 1) ? 1 : c;
    endfunction

    localparam int          BUS_CFG_CYCLES  = ms_to_cycles(BUS_CFG_TIME_MS);
    localparam int          LOGIC_CFG_CYC   = ms_to_cycles(LOGIC_CFG_MS);
    localparam int          INIT_CYCLES     = ms_to_cycles(INIT_TIME_MS);

    localparam logic [4:0]  OFF_CTRL        = 5'h00;
    localparam logic [4:0]  OFF_CHAN        = 5'h04;
    localparam logic [4:0]  OFF_RATE        = 5'h08;
    localparam logic [4:0]  OFF_BUFOPS      = 5'h0c;
    localparam logic [4:0]  OFF_BUILD       = 5'h10;
    localparam logic [4:0]  OFF_CALIB       = 5'h14;
    localparam logic [4:0]  OFF_SAMPLE      = 5'h18;
    localparam logic [4:0]  OFF_ADJCLK      = 5'h1c;

    localparam logic [31:0] CTRL_RST        = 32'h0000_0810;
    localparam logic [15:0] CHAN_RST        = 16'hffff;
    localparam logic [31:0] RATE_RST        = 32'h0000_0096;
    localparam logic [31:0] BUFOPS_RST      = 32'h0000_340f;
    localparam logic [31:0] CALIB_RST       = 32'h0000_0000;
    localparam logic [31:0] ADJCLK_RST      = 32'h0000_0000;
    localparam logic [31:0] CTRL_WMASK      = 32'h00ff_8ffd;
    localparam logic [31:0] BUILD_MASK      = 32'h00ff_ffff;

    localparam int          B_BURST_MODE    = 0;
    localparam int          B_BURST_READY   = 1;
    localparam int          B_SW_TRIG       = 2;
    localparam int          B_REM_GND       = 3;
    localparam int          B_OFFSET_BIN    = 4;
    localparam int          B_DIFF_SYNC     = 5;
    localparam int          B_EXT_BLOCK     = 6;
    localparam int          B_SIMULTANEOUS  = 7;
    localparam int          B_EVENT_LO      = 8;
    localparam int          B_IRQ_FLAG      = 11;
    localparam int          B_SOFT_INIT     = 15;

    localparam logic [2:0]  EV_INIT_DONE    = 3'h0;
    localparam logic [2:0]  EV_BURST_READY  = 3'h1;
    localparam logic [2:0]  EV_BURST_START  = 3'h2;
    localparam logic [2:0]  EV_BURST_DONE   = 3'h3;
endpackage

/* common/cfg_seq_if.sv */
// Purpose: carrier between register bank and configuration sequencer
// Assumes: one clock domain
// Notes:   initStart and initDone are one-cycle pulses
`timescale 1ns/1ps
`default_nettype none
interface cfg_seq_if;
    logic busCfgBusy;
    logic logicCfgBusy;
    logic initBusy;
    logic initDone;
    logic initStart;

    modport sequencer (output busCfgBusy, output logicCfgBusy, output initBusy,
                       output initDone, input initStart);
    modport owner     (input busCfgBusy, input logicCfgBusy, input initBusy,
                       input initDone, output initStart);
endinterface
`default_nettype wire

/* logic/config_sequencer.sv */
// Purpose: bus configuration load, logic load and initialization timing
// Assumes: starts on release of the bus reset
// Notes:   counts are parameters so simulation can shorten them
`timescale 1ns/1ps
`default_nettype none
module config_sequencer #(
    parameter int BUS_CFG_CYCLES = dac_regs_pkg::BUS_CFG_CYCLES,
    parameter int LOGIC_CFG_CYC  = dac_regs_pkg::LOGIC_CFG_CYC,
    parameter int INIT_CYCLES    = dac_regs_pkg::INIT_CYCLES
) (
    input  wire logic  mclk,
    input  wire logic  rst_b,
    cfg_seq_if.sequencer seq
);
    typedef enum logic [1:0] {LOAD_BUS, LOAD_LOGIC, SOFT_INIT_BIT, IDLE} phase_t;
    typedef struct packed {
        phase_t      phase;
        logic [31:0] cnt;
        logic        done;
    } seq_state_t;

    seq_state_t st;
    seq_state_t next_st;

    always_comb
    begin
        next_st = st;
        next_st.done = 1'b0;
        next_st.cnt = st.cnt + 32'h1;
        unique case (st.phase)
            LOAD_BUS:
                if (st.cnt >= 32'(BUS_CFG_CYCLES - 1))
                begin
                    next_st.phase = LOAD_LOGIC;
                    next_st.cnt = '0;
                end
            LOAD_LOGIC:
                if (st.cnt >= 32'(LOGIC_CFG_CYC - 1))
                begin
                    next_st.phase = SOFT_INIT_BIT;
                    next_st.cnt = '0;
                end
            SOFT_INIT_BIT:
                if (st.cnt >= 32'(INIT_CYCLES - 1))
                begin
                    next_st.phase = IDLE;
                    next_st.done = 1'b1;
                end
            IDLE:
            begin
                next_st.cnt = '0;
                if (seq.initStart)
                    next_st.phase = SOFT_INIT_BIT;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            st <= '{phase: LOAD_BUS, cnt: 32'h0, done: 1'b0};
        else
            st <= next_st;
    end

    assign seq.busCfgBusy   = (st.phase == LOAD_BUS);
    assign seq.logicCfgBusy = (st.phase == LOAD_LOGIC);
    assign seq.initBusy     = (st.phase == SOFT_INIT_BIT);
    assign seq.initDone     = st.done;

    bus_load_bound_a: assert property (@(posedge mclk) disable iff (!rst_b)
        st.phase == LOAD_BUS |-> st.cnt < 32'(BUS_CFG_CYCLES))
        else $error("bus configuration load overran its time");
endmodule // config_sequencer
`default_nettype wire

/* logic/burst_trigger.sv */
// Purpose: burst trigger acceptance and burst-running state
// Assumes: trigger pin is asynchronous, burstDone comes from mclk logic
// Notes:   a trigger is a high-to-low change of the filtered pin level
`timescale 1ns/1ps
`default_nettype none
module burst_trigger (
    input  wire logic mclk,
    input  wire logic rst_b,
    input  wire logic burstMode,
    input  wire logic extBlock,
    input  wire logic swTrig,
    input  wire logic trigInPin,
    input  wire logic burstDone,
    output logic      burstReady,
    output logic      trigOutPin
);
    typedef struct packed {
        logic [2:0] sync;
        logic       level;
        logic       busy;
    } trig_state_t;

    trig_state_t st;
    trig_state_t next_st;
    logic        fall;
    logic        accept;

    always_comb
    begin
        next_st = st;
        next_st.sync = {st.sync[1:0], trigInPin};
        if (st.sync[1] == st.sync[2])
            next_st.level = st.sync[2];
        fall = st.level && !next_st.level;
        accept = !st.busy && burstMode && ((fall && !extBlock) || swTrig);
        if (accept)
            next_st.busy = 1'b1;
        else if (burstDone || !burstMode)
            next_st.busy = 1'b0;
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            st <= '{sync: 3'h7, level: 1'b1, busy: 1'b0};
        else
            st <= next_st;
    end

    assign burstReady = !st.busy;
    assign trigOutPin = !st.busy;

    sw_trig_gate_a: assert property (@(posedge mclk) disable iff (!rst_b)
        !burstMode && !st.busy |=> !st.busy)
        else $error("burst started outside burst mode");
    ext_block_a: assert property (@(posedge mclk) disable iff (!rst_b)
        extBlock && !swTrig && !st.busy |=> !st.busy)
        else $error("blocked external trigger started a burst");
    ready_drop_a: assert property (@(posedge mclk) disable iff (!rst_b)
        burstMode && swTrig && burstReady |=> !burstReady)
        else $error("ready stayed high after accepted trigger");
endmodule // burst_trigger
`default_nettype wire

/* logic/dac_board_control_registers.sv */
// Purpose: host-visible control and data register bank of the output board
// Assumes: host accesses arrive from the bridge on the local bus on mclk
// Notes:   one access per request, answered by busAck or busRetry a cycle later
`timescale 1ns/1ps
`default_nettype none
module dac_board_control_registers #(
    parameter int          BUS_CFG_CYCLES = dac_regs_pkg::BUS_CFG_CYCLES,
    parameter int          LOGIC_CFG_CYC  = dac_regs_pkg::LOGIC_CFG_CYC,
    parameter int          INIT_CYCLES    = dac_regs_pkg::INIT_CYCLES,
    // arbitrary value: revision and option code
    parameter logic [31:0] BUILD_OPTIONS  = 32'h0000_0000
) (
    input  wire logic        mclk,
    input  wire logic        rst_b,
    input  wire logic        busSel,
    input  wire logic        busWrite,
    input  wire logic [4:0]  busAddr,
    input  wire logic [31:0] busWdata,
    output logic      [31:0] busRdata,
    output logic             busAck,
    output logic             busRetry,
    output logic             localIrq,
    output logic             burstMode,
    output logic             remoteGndEn,
    output logic             offsetBinary,
    output logic             diffSync,
    output logic             simultaneous,
    output logic      [15:0] chanMask,
    output logic      [31:0] rateWord,
    output logic      [31:0] bufferOps,
    output logic      [31:0] calValues,
    output logic      [31:0] adjClock,
    output logic      [31:0] sampleData,
    output logic             sampleStrobe,
    output logic             initBusy,
    input  wire logic        burstDone,
    input  wire logic        trigInPin,
    output logic             trigOutPin
);
    typedef struct packed {
        logic [31:0] ctrl;
        logic [15:0] chan;
        logic [31:0] rate;
        logic [31:0] bufOps;
        logic [31:0] calib;
        logic [31:0] adjClk;
        logic [31:0] rdata;
        logic        ack;
        logic        retry;
        logic [31:0] sample;
        logic        sampleStb;
        logic        initStart;
        logic        readyPrev;
        logic        irq;
        logic        initBusy;
    } bank_state_t;

    bank_state_t st;
    bank_state_t next_st;
    cfg_seq_if   seq ();
    logic        burstReady;
    logic        take;
    logic        event_hit;
    logic [2:0]  evCode;

    // whole-word address: low two bits carry no meaning
    function automatic logic [4:0] word_addr(input logic [4:0] a);
        return {a[4:2], 2'b00};
    endfunction

    function automatic logic [31:0] read_mux(input bank_state_t s, input logic [4:0] a,
                                             input logic rdy);
        logic [31:0] v;
        v = 32'h0;
        unique case (word_addr(a))
            dac_regs_pkg::OFF_CTRL:
            begin
                v = s.ctrl & dac_regs_pkg::CTRL_WMASK;
                v[dac_regs_pkg::B_BURST_READY] = rdy;
            end
            dac_regs_pkg::OFF_CHAN:   v = {16'h0, s.chan};
            dac_regs_pkg::OFF_RATE:   v = s.rate;
            dac_regs_pkg::OFF_BUFOPS: v = s.bufOps;
            dac_regs_pkg::OFF_BUILD:  v = BUILD_OPTIONS & dac_regs_pkg::BUILD_MASK;
            dac_regs_pkg::OFF_CALIB:  v = s.calib;
            dac_regs_pkg::OFF_SAMPLE: v = 32'h0;
            dac_regs_pkg::OFF_ADJCLK: v = s.adjClk;
            default:                  v = 32'h0;
        endcase
        return v;
    endfunction

    config_sequencer #(
        .BUS_CFG_CYCLES (BUS_CFG_CYCLES),
        .LOGIC_CFG_CYC  (LOGIC_CFG_CYC),
        .INIT_CYCLES    (INIT_CYCLES)
    ) u_seq (
        .mclk  (mclk),
        .rst_b (rst_b),
        .seq   (seq.sequencer)
    );

    burst_trigger u_trig (
        .mclk       (mclk),
        .rst_b      (rst_b),
        .burstMode  (st.ctrl[dac_regs_pkg::B_BURST_MODE]),
        .extBlock   (st.ctrl[dac_regs_pkg::B_EXT_BLOCK]),
        .swTrig     (st.ctrl[dac_regs_pkg::B_SW_TRIG]),
        .trigInPin  (trigInPin),
        .burstDone  (burstDone),
        .burstReady (burstReady),
        .trigOutPin (trigOutPin)
    );

    assign seq.initStart = st.initStart;
    assign evCode = st.ctrl[dac_regs_pkg::B_EVENT_LO +: 3];

    always_comb
    begin
        next_st = st;
        next_st.ack = 1'b0;
        next_st.retry = 1'b0;
        next_st.sampleStb = 1'b0;
        next_st.initStart = 1'b0;
        next_st.readyPrev = burstReady;
        next_st.initBusy = seq.initBusy;
        // software trigger is a pulse: it clears the cycle after it was written
        next_st.ctrl[dac_regs_pkg::B_SW_TRIG] = 1'b0;
        take = busSel && !st.ack && !st.retry;
        if (take && seq.busCfgBusy)
            next_st.retry = 1'b1;
        else if (take)
        begin
            next_st.ack = 1'b1;
            if (busWrite)
            begin
                unique case (word_addr(busAddr))
                    dac_regs_pkg::OFF_CTRL:
                    begin
                        // bits 0, 3-5 and 7 steer the outputs directly
                        next_st.ctrl = busWdata & dac_regs_pkg::CTRL_WMASK;
                        if (busWdata[dac_regs_pkg::B_SOFT_INIT])
                            next_st.initStart = 1'b1;
                    end
                    dac_regs_pkg::OFF_CHAN:   next_st.chan = busWdata[15:0];
                    dac_regs_pkg::OFF_RATE:   next_st.rate = busWdata;
                    dac_regs_pkg::OFF_BUFOPS: next_st.bufOps = busWdata;
                    dac_regs_pkg::OFF_CALIB:  next_st.calib = busWdata;
                    dac_regs_pkg::OFF_SAMPLE:
                    begin
                        next_st.sample = busWdata;
                        next_st.sampleStb = 1'b1;
                    end
                    dac_regs_pkg::OFF_ADJCLK: next_st.adjClk = busWdata;
                    default:                  next_st.rdata = st.rdata;
                endcase
            end
            else
                next_st.rdata = read_mux(st, busAddr, burstReady);
        end
        // soft init and power-up initialization restore every default
        if (seq.initDone)
        begin
            next_st.ctrl = dac_regs_pkg::CTRL_RST;
            next_st.chan = dac_regs_pkg::CHAN_RST;
            next_st.rate = dac_regs_pkg::RATE_RST;
            next_st.bufOps = dac_regs_pkg::BUFOPS_RST;
            next_st.calib = dac_regs_pkg::CALIB_RST;
            next_st.adjClk = dac_regs_pkg::ADJCLK_RST;
        end
        unique case (evCode)
            dac_regs_pkg::EV_INIT_DONE:   event_hit = seq.initDone;
            dac_regs_pkg::EV_BURST_READY: event_hit = burstReady && !st.readyPrev;
            dac_regs_pkg::EV_BURST_START: event_hit = !burstReady && st.readyPrev;
            dac_regs_pkg::EV_BURST_DONE:  event_hit = burstDone;
            default:                      event_hit = 1'b0;
        endcase
        // set wins over a clearing write in the same cycle
        if (event_hit)
            next_st.ctrl[dac_regs_pkg::B_IRQ_FLAG] = 1'b1;
        next_st.irq = next_st.ctrl[dac_regs_pkg::B_IRQ_FLAG]
                      && !seq.busCfgBusy && !seq.logicCfgBusy;
    end

    // reset acts as the bus reset that also restarts configuration loading
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st <= '0;
            st.ctrl <= dac_regs_pkg::CTRL_RST;
            st.chan <= dac_regs_pkg::CHAN_RST;
            st.rate <= dac_regs_pkg::RATE_RST;
            st.bufOps <= dac_regs_pkg::BUFOPS_RST;
            st.calib <= dac_regs_pkg::CALIB_RST;
            st.adjClk <= dac_regs_pkg::ADJCLK_RST;
            st.readyPrev <= 1'b1;
            st.initBusy <= 1'b0;
        end
        else
            st <= next_st;
    end

    assign busRdata     = st.rdata;
    assign busAck       = st.ack;
    assign busRetry     = st.retry;
    assign localIrq     = st.irq;
    assign burstMode    = st.ctrl[dac_regs_pkg::B_BURST_MODE];
    assign remoteGndEn  = st.ctrl[dac_regs_pkg::B_REM_GND];
    assign offsetBinary = st.ctrl[dac_regs_pkg::B_OFFSET_BIN];
    assign diffSync     = st.ctrl[dac_regs_pkg::B_DIFF_SYNC];
    assign simultaneous = st.ctrl[dac_regs_pkg::B_SIMULTANEOUS];
    assign chanMask     = st.chan;
    assign rateWord     = st.rate;
    assign bufferOps    = st.bufOps;
    assign calValues    = st.calib;
    assign adjClock     = st.adjClk;
    assign sampleData   = st.sample;
    assign sampleStrobe = st.sampleStb;
    assign initBusy     = st.initBusy;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    retry_while_loading_a: assert property (
        busSel && !busAck && !busRetry && seq.busCfgBusy |=> busRetry && !busAck)
        else $error("access not retried during configuration load");
    no_write_on_retry_a: assert property (
        busRetry |-> $stable(st.ctrl) || seq.initDone || $past(seq.initDone))
        else $error("retried access changed the control word");
    ctrl_reserved_zero_a: assert property (
        busSel && !busWrite && !busAck && !busRetry && !seq.busCfgBusy
        && word_addr(busAddr) == dac_regs_pkg::OFF_CTRL
        |=> busAck && busRdata[31:24] == 8'h00 && busRdata[14:12] == 3'h0)
        else $error("reserved control bits read nonzero");
    sample_write_a: assert property (
        busSel && busWrite && !busAck && !busRetry && !seq.busCfgBusy
        && word_addr(busAddr) == dac_regs_pkg::OFF_SAMPLE
        |=> sampleStrobe && sampleData == $past(busWdata))
        else $error("sample port write lost");
    sample_read_zero_a: assert property (
        busSel && !busWrite && !busAck && !busRetry && !seq.busCfgBusy
        && word_addr(busAddr) == dac_regs_pkg::OFF_SAMPLE |=> busRdata == 32'h0)
        else $error("write-only port returned data");
    init_defaults_a: assert property (
        seq.initDone |=> st.ctrl == dac_regs_pkg::CTRL_RST
        && st.chan == dac_regs_pkg::CHAN_RST && st.bufOps == dac_regs_pkg::BUFOPS_RST)
        else $error("initialization left a register off its default");
    flag_sets_a: assert property (
        event_hit |=> st.ctrl[dac_regs_pkg::B_IRQ_FLAG])
        else $error("selected event did not set the request flag");
    flag_holds_a: assert property (
        st.ctrl[dac_regs_pkg::B_IRQ_FLAG] && !(busSel && busWrite)
        |=> st.ctrl[dac_regs_pkg::B_IRQ_FLAG])
        else $error("request flag dropped without a clearing write");
    irq_quiet_loading_a: assert property (
        seq.busCfgBusy |=> !localIrq)
        else $error("interrupt asserted during configuration");
    sw_trig_pulse_a: assert property (
        st.ctrl[dac_regs_pkg::B_SW_TRIG] && !(busSel && busWrite)
        |=> !st.ctrl[dac_regs_pkg::B_SW_TRIG])
        else $error("software trigger bit did not self-clear");

    retry_seen_c:   cover property (busRetry);
    soft_init_c:    cover property (st.initStart ##[1:1000] seq.initDone);
    burst_event_c:  cover property (evCode == dac_regs_pkg::EV_BURST_READY && event_hit);
    sample_write_c: cover property (sampleStrobe);
endmodule // dac_board_control_registers
`default_nettype wire

/* testbench/burst_partner.sv */
// Purpose: output-side partner: drives the trigger pin and ends each burst
// Assumes: same mclk as the register bank
// Notes:   the pin idles high like a pulled-up input; a burst lasts ten cycles
`timescale 1ns/1ps
`default_nettype none
module burst_partner (
    input  wire logic mclk,
    input  wire logic pinLow,
    input  wire logic trigOutPin,
    output logic      trigInPin,
    output logic      burstDone
);
    logic [3:0] run;
    assign trigInPin = ~pinLow;
    always_ff @(posedge mclk)
    begin
        run       <= trigOutPin ? 4'h0 : run + 4'h1;
        burstDone <= (run == 4'h8);
    end
endmodule // burst_partner
`default_nettype wire

/* testbench/tb_top.sv */
// Purpose: register bank bench driving the bridge-side access protocol
// Assumes: shortened configuration phases of 20, 40 and 20 cycles
// Notes:   bit 1 of the control word follows burst readiness; reads outside burst mode mask it
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        mclk = 1'b0;
    logic        rst_b = 1'b0;
    logic        busSel = 1'b0;
    logic        busWrite = 1'b0;
    logic        pinLow = 1'b0;
    logic [4:0]  busAddr = 5'h00;
    logic [31:0] busWdata = 32'h0000_0000;
    logic [31:0] busRdata, sampleData, rd, d;
    logic        busAck, busRetry, localIrq, offsetBinary, remoteGndEn, diffSync;
    logic        simultaneous, sampleStrobe, burstDone, trigInPin, trigOutPin, rt;
    logic        burstMode, initBusy;
    logic [15:0] chanMask;
    logic [31:0] rateWord, bufferOps, calValues, adjClock;
    int          n_fail = 0;
    int          total_checks = 0;
    always #5 mclk = ~mclk;
    dac_board_control_registers #(.BUS_CFG_CYCLES(20), .LOGIC_CFG_CYC(40), .INIT_CYCLES(20),
        .BUILD_OPTIONS(32'h0000_0000)) u_dac_board_control_registers (
        .mclk(mclk), .rst_b(rst_b), .busSel(busSel), .busWrite(busWrite),
        .busAddr(busAddr), .busWdata(busWdata), .busRdata(busRdata), .busAck(busAck),
        .busRetry(busRetry), .localIrq(localIrq), .burstMode(burstMode),
        .remoteGndEn(remoteGndEn),
        .offsetBinary(offsetBinary), .diffSync(diffSync), .simultaneous(simultaneous),
        .chanMask(chanMask), .rateWord(rateWord), .bufferOps(bufferOps),
        .calValues(calValues), .adjClock(adjClock),
        .sampleData(sampleData), .sampleStrobe(sampleStrobe), .initBusy(initBusy),
        .burstDone(burstDone), .trigInPin(trigInPin), .trigOutPin(trigOutPin));
    burst_partner u_burst_partner (.mclk(mclk), .pinLow(pinLow), .trigOutPin(trigOutPin),
        .trigInPin(trigInPin), .burstDone(burstDone));
    task automatic finish_test();
        if (n_fail == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk32(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e)
        begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic chk1(input logic g, input logic e);
        chk32({31'h0, g}, {31'h0, e});
    endtask
    // one whole-word access, released in the answer cycle
    task automatic acc(input logic w, input logic [4:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge mclk);
        #1;
        busSel = 1'b1;
        busWrite = w;
        busAddr = a;
        busWdata = wd;
        do
        begin
            @(posedge mclk);
            #1;
            n++;
        end while (busAck !== 1'b1 && busRetry !== 1'b1 && n < 20);
        rd = busRdata;
        rt = busRetry;
        busSel = 1'b0;
        if (n >= 20)
            n_fail++;
    endtask
    task automatic rdc(input logic [4:0] a, input logic [31:0] e, input logic [31:0] m);
        acc(1'b0, a, 32'h0000_0000);
        chk32(rd & m, e & m);
    endtask
    task automatic pulse_pin(input logic e);
        pinLow = 1'b1;
        repeat (8) @(posedge mclk);
        #1;
        chk1(trigOutPin, e);
        pinLow = 1'b0;
    endtask
    initial
    begin
        #50000;
        n_fail++;
        finish_test();
    end
    initial
    begin
        repeat (20) @(posedge mclk);
        #1 rst_b = 1'b1;
        acc(1'b0, dac_regs_pkg::OFF_CTRL, 32'h0000_0000);
        chk1(rt, 1'b1);
        repeat (100) @(posedge mclk);
        rdc(dac_regs_pkg::OFF_CTRL, 32'h0000_0810, 32'hffff_fffd);
        rdc(dac_regs_pkg::OFF_CHAN, 32'h0000_ffff, 32'hffff_ffff);
        rdc(dac_regs_pkg::OFF_RATE, 32'h0000_0096, 32'hffff_ffff);
        rdc(dac_regs_pkg::OFF_BUFOPS, 32'h0000_340f, 32'hffff_ffff);
        chk1(localIrq, 1'b1);
        for (int i = 1; i < 8; i++)
        begin
            d = 32'ha5c3_5a00 | i;
            if (i == 6)
                continue;
            acc(1'b1, 5'(i * 4), d);
            rdc(5'(i * 4), (i == 4) ? 32'h0 : (i == 1) ? d & 32'hffff : d, 32'hffff_ffff);
        end
        rdc(5'h05, 32'h0000_5a01, 32'hffff_ffff);
        chk32({16'h0, chanMask}, 32'h0000_5a01);
        chk32(rateWord, 32'ha5c3_5a02);
        chk32(bufferOps, 32'ha5c3_5a03);
        chk32(calValues, 32'ha5c3_5a05);
        chk32(adjClock, 32'ha5c3_5a07);
        acc(1'b1, dac_regs_pkg::OFF_SAMPLE, 32'h1357_9bdf);
        chk1(sampleStrobe, 1'b1);
        chk32(sampleData, 32'h1357_9bdf);
        rdc(dac_regs_pkg::OFF_SAMPLE, 32'h0, 32'hffff_ffff);
        acc(1'b1, dac_regs_pkg::OFF_CTRL, 32'hff00_70e8);
        rdc(dac_regs_pkg::OFF_CTRL, 32'h0000_00e8, 32'hffff_fffd);
        chk1(remoteGndEn, 1'b1);
        chk1(diffSync, 1'b1);
        chk1(simultaneous, 1'b1);
        chk1(offsetBinary, 1'b0);
        chk1(localIrq, 1'b0);
        acc(1'b1, dac_regs_pkg::OFF_CTRL, 32'h0000_0004);
        repeat (4) @(posedge mclk);
        #1;
        chk1(trigOutPin, 1'b1);
        chk1(burstMode, 1'b0);
        acc(1'b1, dac_regs_pkg::OFF_CTRL, 32'h0000_0201);
        acc(1'b1, dac_regs_pkg::OFF_CTRL, 32'h0000_0205);
        repeat (3) @(posedge mclk);
        #1;
        chk1(trigOutPin, 1'b0);
        chk1(burstMode, 1'b1);
        rdc(dac_regs_pkg::OFF_CTRL, 32'h0000_0a01, 32'hffff_fffb);
        repeat (20) @(posedge mclk);
        acc(1'b1, dac_regs_pkg::OFF_CTRL, 32'h0000_0441);
        rdc(dac_regs_pkg::OFF_CTRL, 32'h0000_0443, 32'hffff_ffff);
        pulse_pin(1'b1);
        acc(1'b1, dac_regs_pkg::OFF_CTRL, 32'h0000_0401);
        pulse_pin(1'b0);
        repeat (20) @(posedge mclk);
        rdc(dac_regs_pkg::OFF_CTRL, 32'h0000_0403, 32'hffff_ffff);
        acc(1'b1, dac_regs_pkg::OFF_CHAN, 32'h0000_0001);
        acc(1'b1, dac_regs_pkg::OFF_CTRL, 32'h0000_8000);
        repeat (5) @(posedge mclk);
        #1;
        chk1(initBusy, 1'b1);
        repeat (35) @(posedge mclk);
        #1;
        chk1(initBusy, 1'b0);
        rdc(dac_regs_pkg::OFF_CHAN, 32'h0000_ffff, 32'hffff_ffff);
        rdc(dac_regs_pkg::OFF_CTRL, 32'h0000_0810, 32'hffff_fffd);
        finish_test();
    end
endmodule // tb_top
`default_nettype wire
